// ### tx_power_and_pa_config_regs.sv
// Power-mode, clock-output start and power-amplifier configuration registers.
// Assumes a host on the serial pins and a low-power request pin from outside mclk.

////////////////////////////////////////////////////////////////////////////////
module tx_power_and_pa_config_regs (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Serial register port
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdoOe,
    // Low-power request pin
    input  wire logic       lowPowerReq,
    // Power controls
    output logic            xoEnable,
    output logic            pllEnable,
    output logic            ampEnable,
    // Clock output
    output logic            clockOutput,
    // Modulator and amplifier settings
    output logic [5:0]      gaussStepControl,
    output logic            ampPowerBoost,
    output logic [7:0]      ampDriverEnable,
    output logic [4:0]      ampShuntCap
);

    ////////////////////////////////////////////////////////////////////////////
    // Serial byte port
    logic [7:0] rxByte;
    logic       rxValid;
    logic       frameActive;
    logic [7:0] txByte_q;
    logic       txLoad_q;

    spi_byte_port u_port (
        .mclk        (mclk),
        .reset       (reset),
        .sclk        (sclk),
        .csN         (csN),
        .sdi         (sdi),
        .sdo         (sdo),
        .sdoOe       (sdoOe),
        .rxByte      (rxByte),
        .rxValid     (rxValid),
        .frameActive (frameActive),
        .txByte      (txByte_q),
        .txLoad      (txLoad_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode: first byte is command and address, second is data
    logic       gotCmd_q;
    logic       isWrite_q;
    logic [6:0] addr_q;
    logic       wrStrobe;
    logic [7:0] readData;

    always_ff @(posedge mclk) begin
        if (reset || !frameActive) begin
            gotCmd_q  <= 1'b0;
            isWrite_q <= 1'b0;
            addr_q    <= '0;
        end else if (rxValid && !gotCmd_q) begin
            gotCmd_q  <= 1'b1;
            isWrite_q <= rxByte[tx_cfg_pkg::CMD_WRITE_BIT];
            addr_q    <= rxByte[6:0];
        end
    end

    // Only the first data byte of a frame is acted on; later bytes are dropped
    logic dataSeen_q;

    always_ff @(posedge mclk) begin
        if (reset || !frameActive) begin
            dataSeen_q <= 1'b0;
        end else if (rxValid && gotCmd_q) begin
            dataSeen_q <= 1'b1;
        end
    end

    assign wrStrobe = rxValid && gotCmd_q && !dataSeen_q && isWrite_q;

    // Read data is loaded in the cycle after the command byte, well before the next falling edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            txByte_q <= '0;
            txLoad_q <= 1'b0;
        end else begin
            txLoad_q <= rxValid && !gotCmd_q && !rxByte[tx_cfg_pkg::CMD_WRITE_BIT];
            txByte_q <= readData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage, implemented bits only
    logic [1:0] startDelay_q;
    logic [2:0] clkReserved_q;
    logic [7:0] reservedCfg_q;
    logic [1:0] lowPowerSelect_q;
    logic [5:0] gaussStep_q;
    logic [2:0] boostReg_q;
    logic [2:0] driverReserved_q;
    logic [2:0] driverCount_q;
    logic [4:0] shuntCap_q;

    // Reserved bits are stored as written; the host keeps their values
    always_ff @(posedge mclk) begin
        if (reset) begin
            startDelay_q  <= tx_cfg_pkg::DLY_RESET;
            clkReserved_q <= tx_cfg_pkg::CLKRSV_RESET;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_CLOCK_OUTPUT_CFG) begin
            startDelay_q  <= rxByte[tx_cfg_pkg::DLY_MSB:tx_cfg_pkg::DLY_LSB];
            clkReserved_q <= rxByte[2:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            reservedCfg_q <= tx_cfg_pkg::RSVD_CFG_RESET;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_RSVD_CFG) begin
            reservedCfg_q <= rxByte;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            lowPowerSelect_q <= tx_cfg_pkg::LP_SHUTDOWN;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_LOW_POWER) begin
            if (rxByte[1:0] == tx_cfg_pkg::LP_REVERT) begin
                lowPowerSelect_q <= tx_cfg_pkg::LP_QUICK;
            end else begin
                lowPowerSelect_q <= rxByte[1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            gaussStep_q <= tx_cfg_pkg::GSTEP_RESET;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_GAUSS_STEP) begin
            gaussStep_q <= rxByte[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            boostReg_q <= tx_cfg_pkg::BOOSTREG_RESET;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_AMP_BOOST) begin
            boostReg_q <= rxByte[2:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            driverReserved_q <= tx_cfg_pkg::DRVRSV_RESET;
            driverCount_q    <= tx_cfg_pkg::DRVCNT_RESET;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_AMP_DRIVER) begin
            driverReserved_q <= rxByte[7:5];
            driverCount_q    <= rxByte[2:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            shuntCap_q <= tx_cfg_pkg::SHUNT_RESET;
        end else if (wrStrobe && addr_q == tx_cfg_pkg::OFS_AMP_SHUNT) begin
            shuntCap_q <= rxByte[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back; unmapped offsets and unimplemented bits read zero
    always_comb begin
        readData = 8'h00;
        unique case (rxByte[6:0])
            tx_cfg_pkg::OFS_CLOCK_OUTPUT_CFG: readData = {startDelay_q, 3'h0, clkReserved_q};
            tx_cfg_pkg::OFS_RSVD_CFG:   readData = reservedCfg_q;
            tx_cfg_pkg::OFS_LOW_POWER:  readData = {6'h00, lowPowerSelect_q};
            tx_cfg_pkg::OFS_GAUSS_STEP: readData = {2'h0, gaussStep_q};
            tx_cfg_pkg::OFS_AMP_BOOST:  readData = {5'h00, boostReg_q};
            tx_cfg_pkg::OFS_AMP_DRIVER: readData = {driverReserved_q, 2'h0, driverCount_q};
            tx_cfg_pkg::OFS_AMP_SHUNT:  readData = {3'h0, shuntCap_q};
            default:                    readData = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-power request synchroniser
    logic lpReqS1_q;
    logic lpReqS2_q;

    always_ff @(posedge mclk) begin
        lpReqS1_q <= lowPowerReq;
        lpReqS2_q <= lpReqS1_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power sequencing
    tx_cfg_pkg::pwr_state_t state_q;
    logic [1:0]             enteredMode_q;
    logic                   delayLoad_q;
    logic                   delayBusy;
    logic [9:0]             delayCycles;

    // Select read when the counter loads on leaving low power, so a write during low power applies to this wake
    always_comb begin
        delayCycles = tx_cfg_pkg::DLY_CYC_CODE0;
        unique case (startDelay_q)
            2'h0: delayCycles = tx_cfg_pkg::DLY_CYC_CODE0;
            2'h1: delayCycles = tx_cfg_pkg::DLY_CYC_CODE1;
            2'h2: delayCycles = tx_cfg_pkg::DLY_CYC_CODE2;
            2'h3: delayCycles = tx_cfg_pkg::DLY_CYC_CODE3;
        endcase
    end

    start_delay_counter u_delay (
        .mclk      (mclk),
        .reset     (reset),
        .load      (delayLoad_q),
        .loadValue (delayCycles),
        .busy      (delayBusy)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q       <= tx_cfg_pkg::ST_RUN;
            enteredMode_q <= tx_cfg_pkg::LP_SHUTDOWN;
            delayLoad_q   <= 1'b0;
        end else begin
            delayLoad_q <= 1'b0;
            unique case (state_q)
                tx_cfg_pkg::ST_RUN: begin
                    if (lpReqS2_q) begin
                        state_q       <= tx_cfg_pkg::ST_LOWPW;
                        enteredMode_q <= lowPowerSelect_q;
                    end
                end
                tx_cfg_pkg::ST_LOWPW: begin
                    if (!lpReqS2_q) begin
                        if (enteredMode_q == tx_cfg_pkg::LP_SHUTDOWN) begin
                            state_q     <= tx_cfg_pkg::ST_WAKE;
                            delayLoad_q <= 1'b1;
                        end else begin
                            state_q <= tx_cfg_pkg::ST_RUN;
                        end
                    end
                end
                tx_cfg_pkg::ST_WAKE: begin
                    // Counter goes busy the cycle after its load
                    if (!delayLoad_q && !delayBusy) begin
                        state_q <= tx_cfg_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_q <= tx_cfg_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Blocks stay powered while waking; only the clock output waits
    always_ff @(posedge mclk) begin
        if (reset) begin
            xoEnable  <= 1'b1;
            pllEnable <= 1'b1;
            ampEnable <= 1'b1;
        end else if (state_q == tx_cfg_pkg::ST_LOWPW) begin
            unique case (enteredMode_q)
                tx_cfg_pkg::LP_SHUTDOWN: begin
                    xoEnable  <= 1'b0;
                    pllEnable <= 1'b0;
                    ampEnable <= 1'b0;
                end
                tx_cfg_pkg::LP_STANDBY: begin
                    xoEnable  <= 1'b1;
                    pllEnable <= 1'b0;
                    ampEnable <= 1'b0;
                end
                default: begin
                    xoEnable  <= 1'b1;
                    pllEnable <= 1'b1;
                    ampEnable <= 1'b0;
                end
            endcase
        end else begin
            xoEnable  <= 1'b1;
            pllEnable <= 1'b1;
            ampEnable <= 1'b1;
        end
    end

    // Clock output runs at half mclk; idle low outside the run state
    always_ff @(posedge mclk) begin
        if (reset) begin
            clockOutput <= 1'b0;
        end else if (state_q == tx_cfg_pkg::ST_RUN) begin
            clockOutput <= ~clockOutput;
        end else begin
            clockOutput <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modulator and amplifier settings
    always_ff @(posedge mclk) begin
        if (reset) begin
            gaussStepControl <= tx_cfg_pkg::GSTEP_RESET;
            ampPowerBoost    <= 1'b0;
            ampShuntCap      <= tx_cfg_pkg::SHUNT_RESET;
        end else begin
            gaussStepControl <= gaussStep_q;
            ampPowerBoost    <= boostReg_q[tx_cfg_pkg::BOOST_BIT];
            ampShuntCap      <= shuntCap_q;
        end
    end

    // Thermometer code: driver i is on when i is not above the count
    always_ff @(posedge mclk) begin
        if (reset) begin
            ampDriverEnable <= 8'h01;
        end else begin
            for (int i = 0; i < 8; i++) begin
                ampDriverEnable[i] <= (3'(i) <= driverCount_q);
            end
        end
    end

endmodule

// ### tx_cfg_pkg.sv
// Constants for the transmitter power and power-amplifier configuration registers.
// Assumes an 8-bit serial register port and a 100 MHz digital clock.
package tx_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame layout
    localparam int unsigned        BYTE_W         = 8;
    localparam int unsigned        ADDR_W         = 7;
    localparam int unsigned        BIT_CNT_W      = 3;
    localparam logic [2:0]         BIT_LAST       = 3'h7;
    localparam int unsigned        CMD_WRITE_BIT  = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [6:0]         OFS_CLOCK_OUTPUT_CFG = 7'h01;
    localparam logic [6:0]         OFS_RSVD_CFG   = 7'h02;
    localparam logic [6:0]         OFS_LOW_POWER  = 7'h03;
    localparam logic [6:0]         OFS_GAUSS_STEP = 7'h04;
    localparam logic [6:0]         OFS_AMP_BOOST  = 7'h05;
    localparam logic [6:0]         OFS_AMP_DRIVER = 7'h06;
    localparam logic [6:0]         OFS_AMP_SHUNT  = 7'h07;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int unsigned        DLY_MSB        = 7;
    localparam int unsigned        DLY_LSB        = 6;
    localparam logic [1:0]         DLY_RESET      = 2'h2;
    localparam logic [2:0]         CLKRSV_RESET   = 3'h1;
    localparam logic [7:0]         RSVD_CFG_RESET = 8'h03;
    localparam logic [1:0]         LPSEL_RESET    = 2'h0;
    localparam logic [5:0]         GSTEP_RESET    = 6'h00;
    localparam logic [2:0]         BOOSTREG_RESET = 3'h4;
    localparam int unsigned        BOOST_BIT      = 0;
    localparam logic [2:0]         DRVRSV_RESET   = 3'h4;
    localparam int unsigned        DRVRSV_LSB     = 5;
    localparam logic [2:0]         DRVCNT_RESET   = 3'h0;
    localparam logic [4:0]         SHUNT_RESET    = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Low-power select codes
    localparam logic [1:0]         LP_SHUTDOWN    = 2'h0;
    localparam logic [1:0]         LP_STANDBY     = 2'h1;
    localparam logic [1:0]         LP_QUICK       = 2'h2;
    localparam logic [1:0]         LP_REVERT      = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Clock-output start delay, in digital clock cycles
    localparam int unsigned        DLY_CNT_W      = 10;
    localparam logic [9:0]         DLY_CYC_CODE0  = 10'h040;
    localparam logic [9:0]         DLY_CYC_CODE1  = 10'h080;
    localparam logic [9:0]         DLY_CYC_CODE2  = 10'h100;
    localparam logic [9:0]         DLY_CYC_CODE3  = 10'h200;

    ////////////////////////////////////////////////////////////////////////////
    // Power sequencing states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_LOWPW = 3'b010,
        ST_WAKE  = 3'b100
    } pwr_state_t;

endpackage

// ### spi_byte_port.sv
// Serial byte port: synchronises the serial pins and moves whole bytes.
// Assumes the serial clock is far slower than mclk (at least eight mclk per phase).
module spi_byte_port (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Serial pins
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdoOe,
    // Byte side
    output logic [7:0]      rxByte,
    output logic            rxValid,
    output logic            frameActive,
    input  wire logic [7:0] txByte,
    input  wire logic       txLoad
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; only the second stage is looked at
    logic       sclkS1_q, sclkS2_q, sclkPrev_q;
    logic       csS1_q, csS2_q;
    logic       sdiS1_q, sdiS2_q;
    logic [6:0] shiftIn_q;
    logic [7:0] shiftOut_q;
    logic [2:0] bitCnt_q;
    logic       rise, fall;

    always_ff @(posedge mclk) begin
        sclkS1_q   <= sclk;
        sclkS2_q   <= sclkS1_q;
        sclkPrev_q <= sclkS2_q;
        csS1_q     <= csN;
        csS2_q     <= csS1_q;
        sdiS1_q    <= sdi;
        sdiS2_q    <= sdiS1_q;
    end

    assign rise = sclkS2_q & ~sclkPrev_q;
    assign fall = ~sclkS2_q & sclkPrev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Receive, most significant bit first, sampled on rising serial clock
    always_ff @(posedge mclk) begin
        if (reset || csS2_q) begin
            bitCnt_q  <= '0;
            shiftIn_q <= '0;
            rxValid   <= 1'b0;
            rxByte    <= '0;
        end else begin
            rxValid <= 1'b0;
            if (rise) begin
                shiftIn_q <= {shiftIn_q[5:0], sdiS2_q};
                bitCnt_q  <= bitCnt_q + 3'h1;
                if (bitCnt_q == tx_cfg_pkg::BIT_LAST) begin
                    rxByte  <= {shiftIn_q, sdiS2_q};
                    rxValid <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit, changed on falling serial clock
    always_ff @(posedge mclk) begin
        if (reset || csS2_q) begin
            shiftOut_q  <= '0;
            sdo         <= 1'b0;
            sdoOe       <= 1'b0;
            frameActive <= 1'b0;
        end else begin
            sdoOe       <= 1'b1;
            frameActive <= 1'b1;
            if (txLoad) begin
                shiftOut_q <= txByte;
            end else if (fall) begin
                sdo        <= shiftOut_q[7];
                shiftOut_q <= {shiftOut_q[6:0], 1'b0};
            end
        end
    end

endmodule

// ### start_delay_counter.sv
// Down counter that stays busy for exactly the loaded number of cycles.
// Assumes a load value of at least one.
module start_delay_counter (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Control
    input  wire logic       load,
    input  wire logic [9:0] loadValue,
    output logic            busy
);

    logic [9:0] cnt_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q <= '0;
            busy  <= 1'b0;
        end else if (load) begin
            cnt_q <= loadValue;
            busy  <= 1'b1;
        end else if (busy) begin
            cnt_q <= cnt_q - 10'h001;
            busy  <= (cnt_q != 10'h001);
        end
    end

endmodule

// ### tx_cfg_regs_sva.sv
// Checker for the power and amplifier configuration block.
// Sees only the block's ports; attached by the bind at the foot of this file.
module tx_cfg_regs_sva (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // Serial pins
    input wire logic       sclk,
    input wire logic       csN,
    input wire logic       sdi,
    input wire logic       sdo,
    input wire logic       sdoOe,
    // Power and settings
    input wire logic       lowPowerReq,
    input wire logic       xoEnable,
    input wire logic       pllEnable,
    input wire logic       ampEnable,
    input wire logic       clockOutput,
    input wire logic [5:0] gaussStepControl,
    input wire logic       ampPowerBoost,
    input wire logic [7:0] ampDriverEnable,
    input wire logic [4:0] ampShuntCap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    AST_DRV_THERMO: assert property (ampDriverEnable[0] && ((ampDriverEnable + 8'h01) & ampDriverEnable) == 8'h00)
        else $error("driver enables not a filled run from bit zero");
    AST_LP_OFF: assert property (lowPowerReq [*8] |-> !ampEnable && !clockOutput)
        else $error("amplifier or clock output alive in low power");
    AST_PLL_XO: assert property (pllEnable |-> xoEnable)
        else $error("synthesizer powered without oscillator");
    AST_WAKE_ALL: assert property (!lowPowerReq [*8] |-> xoEnable && pllEnable && ampEnable)
        else $error("enables not restored after low power");
    // Longest start delay plus synchroniser overhead bounds the wait
    AST_WAKE_BOUND: assert property ($fell(lowPowerReq) |-> ##[1:540] clockOutput)
        else $error("clock output never restarted");
    AST_XO_DELAY: assert property ($rose(xoEnable) |-> !clockOutput [*8])
        else $error("clock output started without delay");
    AST_CLK_HALF: assert property (clockOutput |=> !clockOutput)
        else $error("clock output high two cycles");
    AST_SETTLE: assert property (($changed(gaussStepControl) || $changed(ampShuntCap) || $changed(ampPowerBoost) || $changed(ampDriverEnable)) |-> !csN)
        else $error("setting changed outside a frame");
    AST_OE_END: assert property (csN [*6] |-> !sdoOe)
        else $error("data out driven while deselected");

    cover property ($fell(lowPowerReq));
    cover property (ampDriverEnable == 8'hFF);
    cover property (ampPowerBoost);
endmodule

bind tx_power_and_pa_config_regs tx_cfg_regs_sva i_sva (.mclk, .reset, .sclk, .csN, .sdi, .sdo, .sdoOe,
    .lowPowerReq, .xoEnable, .pllEnable, .ampEnable, .clockOutput, .gaussStepControl, .ampPowerBoost,
    .ampDriverEnable, .ampShuntCap);

// ### spi_host_model.sv
// Host controller model: mode 0 serial master, one register per frame.
// Assumes mclk at 100 MHz; each serial phase lasts ten mclk cycles.
module spi_host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic     sclk,
    output logic     csN,
    output logic     sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    task automatic half();
        repeat (10) @(posedge mclk);
        #1;
    endtask

    // MSB first, change after fall, device samples at rise
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        csN = 1'b0;
        for (int i = 0; i < 16; i++) begin
            sdi = sh[15 - i];
            half();
            sclk = 1'b1;
            if (i >= 8) begin
                rd = {rd[6:0], sdo};
            end
            half();
            sclk = 1'b0;
        end
        half();
        csN = 1'b1;
        // Released line must not keep the last bit
        sdi = ~sdi;
        half();
    endtask
endmodule

// ### testbench.sv
// Self-checking bench for the power and amplifier configuration block.
// Assumes the host model and the checker file are compiled before it.
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin badCount++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       sclk, csN, sdi, sdo, sdoOe;
    logic       lowPowerReq = 1'b0;
    logic       xoEnable, pllEnable, ampEnable, clockOutput, ampPowerBoost;
    logic [5:0] gaussStepControl;
    logic [7:0] ampDriverEnable, gotV, d;
    logic [4:0] ampShuntCap;
    logic [7:0] expQ[$];
    logic [7:0] gotQ[$];
    logic [7:0] expV;
    int         badCount = 0;
    int         numChecks = 0;
    int         n;

    always #5 mclk = ~mclk;

    spi_host_model host (.mclk(mclk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));
    tx_power_and_pa_config_regs i_tx_power_and_pa_config_regs (.mclk(mclk), .reset(reset), .sclk(sclk),
        .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .lowPowerReq(lowPowerReq), .xoEnable(xoEnable),
        .pllEnable(pllEnable), .ampEnable(ampEnable), .clockOutput(clockOutput),
        .gaussStepControl(gaussStepControl), .ampPowerBoost(ampPowerBoost),
        .ampDriverEnable(ampDriverEnable), .ampShuntCap(ampShuntCap));

    ////////////////////////////////////////////////////////////////////////////
    // Scoreboard: oldest note is matched against each published result
    always @(negedge mclk) begin
        while (gotQ.size() > 0) begin
            gotV = gotQ.pop_front();
            expV = expQ.pop_front();
            `CHK(gotV, expV)
        end
    end

    // No delay here, so stimulus keeps its fixed offset from the clock edge
    task automatic want(input logic [7:0] e, input logic [7:0] g);
        expQ.push_back(e);
        gotQ.push_back(g);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] r;
        host.xfer({1'b1, a}, v, r);
    endtask

    task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.xfer({1'b0, a}, 8'h00, r);
        want(e, r);
    endtask

    task automatic resetChk();
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        want(8'h01, ampDriverEnable);
        want(8'h00, {gaussStepControl, ampPowerBoost, ampShuntCap[0]});
    endtask

    task automatic closeOut();
        // Let the scoreboard drain the last notes first
        repeat (2) @(negedge mclk);
        $display("checks %0d errors %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        // Tests need about 34k cycles; allow 60k
        #600000;
        badCount++;
        closeOut();
    end

    initial begin
        void'($urandom(33));
        resetChk();
        // Reset values, with offset zero unmapped
        for (int a = 0; a < 8; a++) begin
            rdChk(7'(a), a == 1 ? 8'h81 : a == 2 ? 8'h03 : a == 5 ? 8'h04 : a == 6 ? 8'h80 : 8'h00);
        end
        wr(7'h20, 8'($urandom()));
        rdChk(7'h20, 8'h00);
        // Every driver count, random values elsewhere with stray upper bits
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom());
            wr(tx_cfg_pkg::OFS_AMP_DRIVER, {3'b100, d[4:3], 3'(i)});
            rdChk(tx_cfg_pkg::OFS_AMP_DRIVER, {3'b100, 2'b00, 3'(i)});
            want(8'((16'h0002 << i) - 16'h0001), ampDriverEnable);
            wr(tx_cfg_pkg::OFS_GAUSS_STEP, d);
            rdChk(tx_cfg_pkg::OFS_GAUSS_STEP, d & 8'h3F);
            want(d & 8'h3F, {2'h0, gaussStepControl});
            wr(tx_cfg_pkg::OFS_AMP_SHUNT, d);
            rdChk(tx_cfg_pkg::OFS_AMP_SHUNT, d & 8'h1F);
            want(d & 8'h1F, {3'h0, ampShuntCap});
            wr(tx_cfg_pkg::OFS_AMP_BOOST, {d[7:3], 2'b10, d[0]});
            rdChk(tx_cfg_pkg::OFS_AMP_BOOST, {5'h00, 2'b10, d[0]});
            want({7'h00, d[0]}, {7'h00, ampPowerBoost});
        end
        resetChk();
        // Each low-power select code, upper bits written as noise
        for (int m = 0; m < 4; m++) begin
            wr(tx_cfg_pkg::OFS_LOW_POWER, {6'($urandom()), 2'(m)});
            rdChk(tx_cfg_pkg::OFS_LOW_POWER, m == 3 ? 8'h02 : 8'(m));
            lowPowerReq = 1'b1;
            repeat (10) @(posedge mclk);
            #1;
            want(m == 0 ? 8'h00 : m == 1 ? 8'h04 : 8'h06, {5'h00, xoEnable, pllEnable, ampEnable});
            lowPowerReq = 1'b0;
            repeat (600) @(posedge mclk);
            #1;
        end
        // Start delay after leaving full shutdown: 64 cycles doubled per code step
        for (int c = 0; c < 4; c++) begin
            wr(tx_cfg_pkg::OFS_CLOCK_OUTPUT_CFG, {2'(c), 6'h00});
            wr(tx_cfg_pkg::OFS_LOW_POWER, 8'h00);
            lowPowerReq = 1'b1;
            repeat (10) @(posedge mclk);
            #1 lowPowerReq = 1'b0;
            n = 0;
            while (clockOutput !== 1'b1 && n < 700) begin
                @(posedge mclk);
                #1 n++;
            end
            want(8'h01, 8'(n >= (64 << c) && n <= (64 << c) + 12));
        end
        closeOut();
    end
endmodule
